//--- idfpu_cfg.svh
// Constants for the instruction decode and float error block.
// Assumes inclusion by every design file that names a code or count.
`ifndef IDFPU_CFG_SVH
`define IDFPU_CFG_SVH

// Function codes, upper nibble
`define IDFPU_FN_J      4'h0
`define IDFPU_FN_PFIX   4'h2
`define IDFPU_FN_NFIX   4'h6
`define IDFPU_FN_CJ     4'ha
`define IDFPU_FN_OPR    4'hf

// Operation codes selected by operate
`define IDFPU_OP_SAVEH  12'h03e
`define IDFPU_OP_SAVEL  12'h03d
`define IDFPU_OP_HFRONT 12'h018
`define IDFPU_OP_HBACK  12'h050
`define IDFPU_OP_LFRONT 12'h01c
`define IDFPU_OP_LBACK  12'h017
`define IDFPU_OP_MEMB   12'h07e
`define IDFPU_OP_PROD   12'h008
`define IDFPU_OP_FMUL   12'h072
`define IDFPU_OP_IN     12'h007
`define IDFPU_OP_OUT    12'h00b
`define IDFPU_OP_OUTW   12'h00f
`define IDFPU_OP_OUTB   12'h00e
`define IDFPU_OP_ALTWT  12'h044
`define IDFPU_OP_TALTWT 12'h051
`define IDFPU_OP_TIN    12'h02b

// Cycle counts
`define IDFPU_CYC_ONE     8'h01
`define IDFPU_CYC_J       8'h03
`define IDFPU_CYC_CJ_NT   8'h02
`define IDFPU_CYC_CJ_T    8'h04
`define IDFPU_CYC_SAVE    8'h04
`define IDFPU_CYC_PROD_P  8'h04
`define IDFPU_CYC_PROD_N  8'h05
`define IDFPU_CYC_FMUL    8'h23
`define IDFPU_CYC_FMUL_R  8'h28

`endif

//--- idfpu_pkg.sv
// Types shared by the decode block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package idfpu_pkg;
   // Float unit instruction classes
   typedef enum logic [2:0] {
      IDFPU_FP_ARITH = 3'h0,
      IDFPU_FP_SET   = 3'h1,
      IDFPU_FP_CLEAR = 3'h2,
      IDFPU_FP_TEST  = 3'h3,
      IDFPU_FP_CHECK = 3'h4,
      IDFPU_FP_OTHER = 3'h5
   } idfpu_fp_kind_t;
   // Execution timer states
   typedef enum logic [0:0] {
      IDFPU_IDLE = 1'b0,
      IDFPU_BUSY = 1'b1
   } idfpu_tmr_st_t;
endpackage

//--- idfpu_cycle_timer.sv
// Execution timer: holds the decoder busy for a loaded cycle count.
// Assumes load only while idle and a count of at least one.
`timescale 1ns/10ps
`include "idfpu_cfg.svh"
module idfpu_cycle_timer #(
   parameter int CYC_W = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic [CYC_W-1:0] cycles,
   output logic                  idle,
   output logic                  done
);
   idfpu_pkg::idfpu_tmr_st_t st_q, st_d;
   logic [CYC_W-1:0] left_q, left_d;   // Cycles still to run
   logic             done_q, done_d;   // Retire pulse

   // Next state; the load cycle is the first execution cycle
   always_comb begin
      st_d   = st_q;
      left_d = left_q;
      done_d = 1'b0;
      unique case (st_q)
         idfpu_pkg::IDFPU_IDLE: begin
            if (load && cycles == CYC_W'(`IDFPU_CYC_ONE)) begin
               done_d = 1'b1;
            end else if (load) begin
               st_d   = idfpu_pkg::IDFPU_BUSY;
               left_d = cycles - CYC_W'(`IDFPU_CYC_ONE);
            end
         end
         idfpu_pkg::IDFPU_BUSY: begin
            left_d = left_q - CYC_W'(`IDFPU_CYC_ONE);
            if (left_q == CYC_W'(`IDFPU_CYC_ONE)) begin
               st_d   = idfpu_pkg::IDFPU_IDLE;
               done_d = 1'b1;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q   <= idfpu_pkg::IDFPU_IDLE;
         left_q <= '0;
         done_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         left_q <= left_d;
         done_q <= done_d;
      end
   end

   assign idle = (st_q == idfpu_pkg::IDFPU_IDLE);
   assign done = done_q;
endmodule

//--- idfpu_float_unit_error_flag.sv
// Float unit error flag and its link to the main error flag.
// Assumes one classified float instruction per valid pulse.
`timescale 1ns/10ps
module idfpu_float_unit_error_flag (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          fp_valid,
   input  wire idfpu_pkg::idfpu_fp_kind_t     fp_kind,
   input  wire logic                          fp_invalid,
   input  wire logic                          fp_div_zero,
   input  wire logic                          fp_overflow,
   input  wire logic                          fp_in_inf,
   input  wire logic                          fp_in_nan,
   input  wire logic                          int_err_set,
   input  wire logic                          int_err_clr,
   output logic                               float_unit_error_flag,
   output logic                               error_flag,
   output logic                               fp_test_result
);
   logic fe_q, fe_d;     // Float error flag
   logic me_q, me_d;     // Main error flag
   logic tst_q, tst_d;   // Last test answer
   wire  is_arith = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_ARITH;
   wire  is_set   = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_SET;
   wire  is_clr   = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_CLEAR;
   wire  is_test  = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_TEST;
   wire  is_chk   = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_CHECK;
   wire  exc      = fp_invalid || fp_div_zero || fp_overflow;
   wire  bad_in   = fp_in_inf || fp_in_nan;

   // Flag updates; a new fault beats a clear in the same cycle
   always_comb begin
      fe_d  = fe_q;
      me_d  = me_q;
      tst_d = tst_q;
      if (is_clr || is_test) begin
         fe_d = 1'b0;
      end
      if (is_set || (is_arith && (exc || bad_in))) begin
         fe_d = 1'b1;
      end
      if (is_test) begin
         tst_d = fe_q;
      end
      if (int_err_clr) begin
         me_d = 1'b0;
      end
      if (int_err_set || (is_chk && fe_q)) begin
         me_d = 1'b1;
      end
   end

   // Flag registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fe_q  <= 1'b0;
         me_q  <= 1'b0;
         tst_q <= 1'b0;
      end else begin
         fe_q  <= fe_d;
         me_q  <= me_d;
         tst_q <= tst_d;
      end
   end

   assign float_unit_error_flag = fe_q;
   assign error_flag            = me_q;
   assign fp_test_result        = tst_q;
endmodule

//--- idfpu_decode.sv
// Instruction byte decoder with cycle timing and float error control.
// Assumes bytes from internal memory, one per accepted handshake,
// and a stack top value that is stable while a byte is offered.
`timescale 1ns/10ps
`include "idfpu_cfg.svh"
module idfpu_decode #(
   parameter int WORD_W = 16,   // Processor word width
   parameter int CYC_W  = 8     // Cycle counter width
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic [7:0]                instr_byte,
   input  wire logic                      instr_valid,
   output logic                           instr_ready,
   input  wire logic [WORD_W-1:0]         stack_top,
   input  wire logic                      frac_round,
   input  wire logic                      analyse_pin,
   input  wire logic                      fp_valid,
   input  wire idfpu_pkg::idfpu_fp_kind_t fp_kind,
   input  wire logic                      fp_invalid,
   input  wire logic                      fp_div_zero,
   input  wire logic                      fp_overflow,
   input  wire logic                      fp_in_inf,
   input  wire logic                      fp_in_nan,
   input  wire logic                      int_err_set,
   input  wire logic                      int_err_clr,
   output logic [3:0]                     func_code,
   output logic [WORD_W-1:0]              operand,
   output logic [CYC_W-1:0]               exec_cycles,
   output logic                           exec_done,
   output logic                           conditional_branch,
   output logic                           save_high_queue,
   output logic                           save_low_queue,
   output logic                           load_high_front,
   output logic                           load_high_back,
   output logic                           load_low_front,
   output logic                           load_low_back,
   output logic                           push_user_memory_base,
   output logic                           illegal_op,
   output logic                           desched_point,
   output logic                           analyse_halted,
   output logic                           float_unit_error_flag,
   output logic                           error_flag,
   output logic                           fp_test_result
);
   // Highest set bit of a word, zero for a zero word
   function automatic logic [CYC_W-1:0] top_bit(input logic [WORD_W-1:0] v);
      logic [CYC_W-1:0] r;
      r = '0;
      for (int i = 0; i < WORD_W; i++) begin
         if (v[i]) begin
            r = CYC_W'(i);
         end
      end
      return r;
   endfunction

   // Handshake and byte split
   logic             timer_idle;      // No instruction in flight
   logic             timer_done;      // Retire pulse from timer
   // Same as the port handshake, so a halt refuses bytes
   wire              take = instr_valid && instr_ready;
   // Upper nibble function, lower nibble data
   wire [3:0]        fn   = instr_byte[7:4];
   wire [3:0]        dat  = instr_byte[3:0];

   // Operand accumulation across prefix bytes
   // Operate codes above twelve bits match nothing
   logic [WORD_W-1:0] acc_q, acc_d;   // Held prefix value
   wire  [WORD_W-1:0] oper = acc_q | WORD_W'(dat);
   wire  [11:0]       opc  = oper[11:0];
   wire               hi_z = (oper >> 12) == '0;

   // Function decode
   wire is_pfix = fn == `IDFPU_FN_PFIX;
   wire is_nfix = fn == `IDFPU_FN_NFIX;
   wire is_j    = fn == `IDFPU_FN_J;
   wire is_cj   = fn == `IDFPU_FN_CJ;
   wire is_opr  = fn == `IDFPU_FN_OPR;
   wire op_hit  = is_opr && hi_z;

   // Operation decode
   wire op_saveh  = op_hit && opc == `IDFPU_OP_SAVEH;
   wire op_savel  = op_hit && opc == `IDFPU_OP_SAVEL;
   wire op_hfront = op_hit && opc == `IDFPU_OP_HFRONT;
   wire op_hback  = op_hit && opc == `IDFPU_OP_HBACK;
   wire op_lfront = op_hit && opc == `IDFPU_OP_LFRONT;
   wire op_lback  = op_hit && opc == `IDFPU_OP_LBACK;
   wire op_memb   = op_hit && opc == `IDFPU_OP_MEMB;
   wire op_prod   = op_hit && opc == `IDFPU_OP_PROD;
   wire op_fmul   = op_hit && opc == `IDFPU_OP_FMUL;

   // Channel and timer waits that may give up the processor
   // Loop and process ends are not decoded
   wire op_wait = op_hit && (opc == `IDFPU_OP_IN || opc == `IDFPU_OP_OUT
                  || opc == `IDFPU_OP_OUTW || opc == `IDFPU_OP_OUTB
                  || opc == `IDFPU_OP_ALTWT || opc == `IDFPU_OP_TALTWT
                  || opc == `IDFPU_OP_TIN);
   // Points where a process may stop
   wire dpoint  = is_j || op_wait;

   // Branch condition: jump when the stack top is zero
   wire br_take = stack_top == '0;

   // Product timing; the sign picks the longer path
   // Zero counts as positive: four cycles
   wire              a_neg  = stack_top[WORD_W-1];
   wire [WORD_W-1:0] a_abs  = a_neg ? (~stack_top + WORD_W'(1)) : stack_top;
   wire [CYC_W-1:0]  cyc_pp = top_bit(stack_top) + CYC_W'(`IDFPU_CYC_PROD_P);
   wire [CYC_W-1:0]  cyc_pn = top_bit(a_abs) + CYC_W'(`IDFPU_CYC_PROD_N);

   // Narrow words lack the fractional multiply
   wire wide    = WORD_W >= 32;
   wire bad_op  = op_fmul && !wide;

   // Cycle count of the byte being taken
   logic [CYC_W-1:0] cyc;
   always_comb begin
      // Unlisted operations take one cycle
      cyc = CYC_W'(`IDFPU_CYC_ONE);
      if (is_pfix || is_nfix) begin
         cyc = CYC_W'(`IDFPU_CYC_ONE);
      end else if (is_j) begin
         cyc = CYC_W'(`IDFPU_CYC_J);
      end else if (is_cj) begin
         cyc = br_take ? CYC_W'(`IDFPU_CYC_CJ_T) : CYC_W'(`IDFPU_CYC_CJ_NT);
      end else if (op_saveh || op_savel) begin
         cyc = CYC_W'(`IDFPU_CYC_SAVE);
      end else if (op_hfront || op_hback || op_lfront || op_lback || op_memb) begin
         cyc = CYC_W'(`IDFPU_CYC_ONE);
      end else if (op_prod) begin
         cyc = a_neg ? cyc_pn : cyc_pp;
      end else if (op_fmul && wide) begin
         cyc = frac_round ? CYC_W'(`IDFPU_CYC_FMUL_R) : CYC_W'(`IDFPU_CYC_FMUL);
      end
   end

   // Prefix chain: shift, or invert then shift for negative prefix
   always_comb begin
      acc_d = acc_q;
      if (take) begin
         if (is_pfix) begin
            acc_d = oper << 4;
         end else if (is_nfix) begin
            acc_d = (~oper) << 4;
         end else begin
            acc_d = '0;
         end
      end
   end

   // Analyse pin crosses in from outside the clock
   // Reset low matches the idle pin level
   logic an_s1_q, an_s2_q, an_s3_q;   // Three stage synchroniser
   logic an_q;                        // Accepted level
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         an_s1_q <= 1'b0;
         an_s2_q <= 1'b0;
         an_s3_q <= 1'b0;
      end else begin
         an_s1_q <= analyse_pin;
         an_s2_q <= an_s1_q;
         an_s3_q <= an_s2_q;
      end
   end

   // Level changes only once the last two stages agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         an_q <= 1'b0;
      end else if (an_s2_q == an_s3_q) begin
         an_q <= an_s3_q;
      end
   end

   // Halt latch; it stays until the pin is released
   logic halt_q, halt_d;
   always_comb begin
      halt_d = halt_q;
      if (!an_q) begin
         halt_d = 1'b0;
      end
      // Halt lands only on a point
      if (an_q && take && dpoint) begin
         halt_d = 1'b1;
      end
   end

   // Registered decode outputs; strobes pulse for one cycle, fields hold until the next take
   logic [3:0]        fn_q;
   logic [WORD_W-1:0] op_q;
   logic [CYC_W-1:0]  cyc_q;
   logic [9:0]        act_q;   // Action strobes
   // Branch strobe fires taken or not
   wire  [9:0]        act_d = take ? {dpoint, bad_op,
                                      op_memb, op_lback, op_lfront, op_hback,
                                      op_hfront, op_savel, op_saveh,
                                      is_cj} : 10'h000;

   // Operand and strobe registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acc_q  <= '0;
         fn_q   <= 4'h0;
         op_q   <= '0;
         cyc_q  <= '0;
         act_q  <= 10'h000;
         halt_q <= 1'b0;
      end else begin
         acc_q  <= acc_d;
         act_q  <= act_d;
         halt_q <= halt_d;
         if (take) begin
            fn_q  <= fn;
            op_q  <= oper;
            cyc_q <= cyc;
         end
      end
   end

   // Execution timer; a halt stops further bytes
   // Only an idle timer is ever loaded
   idfpu_cycle_timer #(
      .CYC_W (CYC_W)
   ) u_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (take),
      .cycles  (cyc),
      .idle    (timer_idle),
      .done    (timer_done)
   );

   // Float error flag and main error flag
   // Runs beside the byte stream
   idfpu_float_unit_error_flag u_fperr (
      .ref_clk               (ref_clk),
      .rst                   (rst),
      .fp_valid              (fp_valid),
      .fp_kind               (fp_kind),
      .fp_invalid            (fp_invalid),
      .fp_div_zero           (fp_div_zero),
      .fp_overflow           (fp_overflow),
      .fp_in_inf             (fp_in_inf),
      .fp_in_nan             (fp_in_nan),
      .int_err_set           (int_err_set),
      .int_err_clr           (int_err_clr),
      .float_unit_error_flag (float_unit_error_flag),
      .error_flag            (error_flag),
      .fp_test_result        (fp_test_result)
   );

   // Hold off new bytes while busy or halted
   assign instr_ready           = timer_idle && !halt_q;
   assign func_code             = fn_q;
   assign operand               = op_q;
   assign exec_cycles           = cyc_q;
   assign exec_done             = timer_done;
   // Strobes stand one cycle after the take
   assign conditional_branch    = act_q[0];
   assign save_high_queue       = act_q[1];
   assign save_low_queue        = act_q[2];
   assign load_high_front       = act_q[3];
   assign load_high_back        = act_q[4];
   assign load_low_front        = act_q[5];
   assign load_low_back         = act_q[6];
   assign push_user_memory_base = act_q[7];
   assign illegal_op            = act_q[8];
   assign desched_point         = act_q[9];
   assign analyse_halted        = halt_q;
endmodule

//--- idfpu_decode_sva.sv
// Checker for the decode block: timing, strobes and error flags.
// Assumes it is bound into the decode top and sees its ports only.
`timescale 1ns/10ps
module idfpu_decode_sva #(
   parameter int WORD_W = 16,  // Word width, as the design
   parameter int CYC_W  = 8    // Count width, as the design
) (
   input wire logic                      ref_clk,
   input wire logic                      rst,
   input wire logic [7:0]                instr_byte,
   input wire logic                      instr_valid,
   input wire logic                      instr_ready,
   input wire logic [WORD_W-1:0]         stack_top,
   input wire logic                      fp_valid,
   input wire idfpu_pkg::idfpu_fp_kind_t fp_kind,
   input wire logic                      fp_invalid,
   input wire logic                      fp_div_zero,
   input wire logic                      fp_overflow,
   input wire logic                      fp_in_inf,
   input wire logic                      fp_in_nan,
   input wire logic                      int_err_set,
   input wire logic                      int_err_clr,
   input wire logic [3:0]                func_code,
   input wire logic [CYC_W-1:0]          exec_cycles,
   input wire logic                      exec_done,
   input wire logic                      conditional_branch,
   input wire logic                      save_high_queue,
   input wire logic                      save_low_queue,
   input wire logic                      load_high_front,
   input wire logic                      load_high_back,
   input wire logic                      load_low_front,
   input wire logic                      load_low_back,
   input wire logic                      push_user_memory_base,
   input wire logic                      illegal_op,
   input wire logic                      desched_point,
   input wire logic                      analyse_halted,
   input wire logic                      float_unit_error_flag,
   input wire logic                      error_flag
);
   // One clock domain throughout
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Float classes decoded once
   wire arith_op = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_ARITH;
   wire check_op = fp_valid && fp_kind == idfpu_pkg::IDFPU_FP_CHECK;

   a_byte_split_nibble: assert property (instr_valid && instr_ready |=>
      func_code == $past(instr_byte) >> 4) else $error("function nibble wrong");
   a_branch_time: assert property (conditional_branch |->
      exec_cycles == (($past(stack_top) == 0) ? 4 : 2)) else $error("branch count wrong");
   a_save_high_len: assert property (save_high_queue |->
      exec_cycles == 4 && !exec_done ##1 !exec_done [*2] ##1 exec_done)
      else $error("high save length wrong");
   a_save_low_len: assert property (save_low_queue |->
      !instr_ready [*3] ##1 instr_ready && exec_done) else $error("low save length wrong");
   a_high_load_one: assert property (load_high_front || load_high_back |->
      exec_done && exec_cycles == 1) else $error("high load length");
   a_low_load_one: assert property (load_low_front || load_low_back |->
      exec_done && exec_cycles == 1) else $error("low load length");
   a_push_base_one: assert property (push_user_memory_base |->
      exec_done && exec_cycles == 1) else $error("base push length");
   a_narrow_fmul_only: assert property (illegal_op |-> exec_done && WORD_W < 32)
      else $error("bad refusal");
   a_arith_exception: assert property (arith_op &&
      (fp_invalid || fp_div_zero || fp_overflow) |=> float_unit_error_flag)
      else $error("exception missed");
   a_arith_bad_input: assert property (arith_op && (fp_in_inf || fp_in_nan)
      |=> float_unit_error_flag) else $error("bad input missed");
   a_main_isolated: assert property (fp_valid && !int_err_set && !int_err_clr &&
      fp_kind inside {idfpu_pkg::IDFPU_FP_SET, idfpu_pkg::IDFPU_FP_CLEAR,
      idfpu_pkg::IDFPU_FP_TEST} |=> $stable(error_flag)) else $error("main flag moved");
   a_check_sets_main: assert property (check_op && float_unit_error_flag |=> error_flag)
      else $error("check did not set main flag");
   a_float_flag_held: assert property (!fp_valid |=> $stable(float_unit_error_flag))
      else $error("float flag moved");
   a_halt_at_desched: assert property ($rose(analyse_halted) |-> desched_point)
      else $error("halt outside descheduling point");

   // Main scenarios reached
   c_save_high: cover property (save_high_queue);
   c_branch_taken: cover property (conditional_branch && exec_cycles == 4);
   c_check_hit: cover property (check_op && float_unit_error_flag);
   c_halted: cover property (analyse_halted);
endmodule

bind idfpu_decode idfpu_decode_sva #(.WORD_W(WORD_W), .CYC_W(CYC_W)) i_idfpu_decode_sva (.*);

//--- idfpu_decode_bench.sv
// Self-checking bench for the decode block.
// Assumes the design and its checker are compiled first.
`timescale 1ns/10ps
module idfpu_decode_bench;
   logic                      ref_clk, rst, instr_valid, instr_ready, frac_round, analyse_pin;
   logic [7:0]                instr_byte, exec_cycles;
   logic [15:0]               stack_top, operand;
   logic [3:0]                func_code;
   logic                      fp_valid, fp_invalid, fp_div_zero, fp_overflow, fp_in_inf;
   logic                      fp_in_nan, int_err_set, int_err_clr, exec_done;
   idfpu_pkg::idfpu_fp_kind_t fp_kind;
   logic                      conditional_branch, save_high_queue, save_low_queue;
   logic                      load_high_front, load_high_back, load_low_front, load_low_back;
   logic                      push_user_memory_base, illegal_op, desched_point;
   logic                      analyse_halted, float_unit_error_flag, error_flag, fp_test_result;
   int                        errors, n_tests;
   logic [31:0]               rnd;          // Random source state
   logic                      m_fe, m_err, m_tr; // Expected flag values
   // All strobes as one word, strongest first
   wire [9:0] strb = {conditional_branch, save_high_queue, save_low_queue, load_high_front,
      load_high_back, load_low_front, load_low_back, push_user_memory_base, illegal_op,
      desched_point};
   // Op table: code, cycles, strobe; the first eight entries take two bytes
   localparam logic [15:0] op_code [10] = '{16'h23fe, 16'h23fd, 16'h21f8, 16'h25f0,
      16'h21fc, 16'h21f7, 16'h27fe, 16'h27f2, 16'h0000, 16'h00f7};
   localparam logic [7:0] op_cyc [10] = '{8'h04, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01,
      8'h01, 8'h01, 8'h03, 8'h01};
   localparam logic [9:0] op_strb [10] = '{10'h100, 10'h080, 10'h040, 10'h020, 10'h010,
      10'h008, 10'h004, 10'h002, 10'h001, 10'h001};
   localparam logic [15:0] corner [5] = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'hffff};

   idfpu_decode i_idfpu_decode (.*);

   // Free-running clock, 4 ns
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Product cost from the magnitude's top bit
   function automatic logic [7:0] exp_prod(input logic [15:0] a);
      logic [16:0] m;
      logic [7:0]  r;
      m = a[15] ? 17'h10000 - {1'b0, a} : {1'b0, a};
      r = 8'h00;
      for (int i = 0; i < 17; i++) if (m[i]) r = i[7:0];
      return a[15] ? r + 8'h05 : r + 8'h04;
   endfunction

   task automatic report_and_stop;
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask

   // Bounded wait for ready, then the taking edge
   task automatic wait_take;
      int k;
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (instr_ready !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         report_and_stop();
      end
      @(posedge ref_clk);
   endtask

   // Issue one or two bytes, then time the retirement
   task automatic run(input logic [15:0] code, input logic two, input logic [7:0] n,
                      input logic [9:0] s, input logic [15:0] a);
      int k;
      @(posedge ref_clk);
      stack_top   <= a;
      instr_byte  <= two ? code[15:8] : code[7:0];
      instr_valid <= 1'b1;
      if (two) begin
         wait_take();
         instr_byte <= code[7:0];
      end
      wait_take();
      instr_valid <= 1'b0;
      @(negedge ref_clk);
      cmp_word({22'h0, strb}, {22'h0, s});
      cmp_word({24'h0, exec_cycles}, {24'h0, n});
      cmp_word({28'h0, func_code}, {28'h0, code[7:4]});
      cmp_word({16'h0, operand}, two ? {24'h0, code[11:8], code[3:0]} : {28'h0, code[3:0]});
      k = 1;
      while (exec_done !== 1'b1 && k < 300) begin
         @(negedge ref_clk);
         k++;
      end
      cmp_word(k, {24'h0, n});
      cmp_flag(float_unit_error_flag, m_fe);
   endtask

   // One float instruction against the flag model
   task automatic fp_step(input logic [2:0] k, input logic [4:0] q, input logic s,
                          input logic c);
      @(posedge ref_clk);
      fp_valid    <= 1'b1;
      fp_kind     <= idfpu_pkg::idfpu_fp_kind_t'(k);
      {fp_invalid, fp_div_zero, fp_overflow, fp_in_inf, fp_in_nan} <= q;
      int_err_set <= s;
      int_err_clr <= c;
      @(posedge ref_clk);
      fp_valid    <= 1'b0;
      int_err_set <= 1'b0;
      int_err_clr <= 1'b0;
      // Set beats clear on the main flag
      if (s || (k == 3'h4 && m_fe)) m_err = 1'b1;
      else if (c) m_err = 1'b0;
      if (k == 3'h3) m_tr = m_fe;
      if ((k == 3'h0 && |q) || k == 3'h1) m_fe = 1'b1;
      else if (k == 3'h2 || k == 3'h3) m_fe = 1'b0;
      @(negedge ref_clk);
      cmp_flag(float_unit_error_flag, m_fe);
      cmp_flag(error_flag, m_err);
      cmp_flag(fp_test_result, m_tr);
   endtask

   // Main sequence
   initial begin
      int k;
      logic [15:0] a;
      {instr_valid, frac_round, analyse_pin, fp_valid, int_err_set, int_err_clr} = 6'h00;
      {fp_invalid, fp_div_zero, fp_overflow, fp_in_inf, fp_in_nan} = 5'h00;
      instr_byte = 8'h00;
      stack_top  = 16'h0000;
      fp_kind    = idfpu_pkg::IDFPU_FP_OTHER;
      {errors, n_tests} = '0;
      {m_fe, m_err, m_tr} = 3'h0;
      rnd = 32'ha1c9;
      rst = 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      // Single exception classes one at a time
      for (int j = 0; j < 5; j++) begin
         fp_step(3'h2, 5'h00, 1'b0, 1'b0);
         fp_step(3'h0, 5'h01 << j, 1'b0, 1'b0);
      end
      fp_step(3'h5, 5'h00, 1'b0, 1'b1);
      fp_step(3'h4, 5'h00, 1'b0, 1'b0);
      fp_step(3'h1, 5'h00, 1'b0, 1'b0);
      // Random float traffic
      repeat (80) begin
         rnd = lfsr(rnd);
         fp_step(rnd[2:0] % 3'h6, rnd[12:8] & {5{rnd[13]}}, &rnd[22:20], &rnd[24:23]);
      end
      // Every listed operation, stack value random
      for (int i = 0; i < 10; i++) begin
         rnd = lfsr(rnd);
         run(op_code[i], i < 8, op_cyc[i], op_strb[i], rnd[15:0]);
      end
      run(16'h00a3, 1'b0, 8'h04, 10'h200, 16'h0000);
      run(16'h00a3, 1'b0, 8'h02, 10'h200, 16'h0040);
      // Product timing, corners then random
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         a = (i < 5) ? corner[i] : rnd[15:0];
         run(16'h00f8, 1'b0, exp_prod(a), 10'h000, a);
      end
      // Analyse: ignored off points, halts at a jump
      @(posedge ref_clk);
      analyse_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      run(16'h21f8, 1'b1, 8'h01, 10'h040, 16'h0001);
      cmp_flag(analyse_halted, 1'b0);
      run(16'h0000, 1'b0, 8'h03, 10'h001, 16'h0001);
      cmp_flag(analyse_halted, 1'b1);
      cmp_flag(instr_ready, 1'b0);
      @(posedge ref_clk);
      analyse_pin <= 1'b0;
      k = 0;
      while (analyse_halted !== 1'b0 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      cmp_flag(analyse_halted, 1'b0);
      report_and_stop();
   end
endmodule
